// file: core/awh_top.sv
`timescale 1ns/1ps
module awh_top #(
  parameter int STAB_LONG_CYC = awh_pkg::STAB_LONG,
  parameter int PLL_START_CYC = awh_pkg::PLL_START_CYC_DEF
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic halt_exec_i,
  input wire logic rc_tick_i,
  input wire logic ext_wake_i,
  input wire logic wdg_active_i,
  input wire logic wdg_halt_opt_i,
  input wire logic long_stab_opt_i,
  input wire logic pll_opt_i,
  output logic main_osc_en_o,
  output logic periph_clk_en_o,
  output logic cpu_run_o,
  output logic rc_osc_en_o,
  output logic capture_sel_o,
  output logic irq_mask_clr_o,
  output logic wdg_reset_o,
  output logic wake_irq_o,
  output logic irq_o
);
  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [31:0] a, input logic [7:0] idx);
    hit = (a == {22'h0, idx, 2'b00});
  endfunction : hit

  logic wr_acc;
  logic rd_acc;
  assign wr_acc = psel_i && penable_i && pwrite_i;
  assign rd_acc = psel_i && penable_i && !pwrite_i;

  // ---------------------------------------------------------------
  // register selects
  // ---------------------------------------------------------------
  logic sel_pre;
  logic sel_csr;
  logic sel_msk;
  logic sel_ist;
  logic sel_sta;
  logic sel_any;

  // one compare per register, shared by read, write and clear paths
  assign sel_pre = hit(paddr_i, awh_pkg::PRESCALER_IDX);
  assign sel_csr = hit(paddr_i, awh_pkg::CTRL_STAT_IDX);
  assign sel_msk = hit(paddr_i, awh_pkg::IRQ_MASK_IDX);
  assign sel_ist = hit(paddr_i, awh_pkg::IRQ_STAT_IDX);
  assign sel_sta = hit(paddr_i, awh_pkg::STATUS_IDX);
  assign sel_any = sel_pre || sel_csr || sel_msk || sel_ist || sel_sta;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  awh_pkg::awh_state_t st_q, st_d;
  logic [7:0] pre_q, pre_d;
  logic en_q, en_d;
  logic meas_q, meas_d;
  logic flag_q, flag_d;
  logic [awh_pkg::IRQ_WIDTH-1:0] msk_q, msk_d;
  logic [awh_pkg::IRQ_WIDTH-1:0] ist_q, ist_d;
  logic [5:0] div_q, div_d;
  logic [7:0] psc_q, psc_d;
  logic [12:0] cnt_q, cnt_d;
  logic [31:0] rdata_q, rdata_d;
  logic ready_q, ready_d;
  logic err_q, err_d;
  logic mclr_q, mclr_d;
  logic wdg_q, wdg_d;
  logic [12:0] stab_cyc;
  logic expire;
  logic wdg_evt;

  assign stab_cyc = long_stab_opt_i ? 13'(STAB_LONG_CYC) : 13'(awh_pkg::STAB_SHORT);
  assign expire = (st_q == awh_pkg::AWH_COUNT) && rc_tick_i &&
                  (div_q == 6'(awh_pkg::FIXED_DIV - 1)) &&
                  (psc_q + 8'h01 >= pre_q);
  assign wdg_evt = (st_q == awh_pkg::AWH_RUN) && halt_exec_i && wdg_active_i &&
                   wdg_halt_opt_i;

  // power sequence and counters
  always_comb begin
    st_d = st_q;
    div_d = div_q;
    psc_d = psc_q;
    cnt_d = cnt_q;
    mclr_d = 1'b0;
    wdg_d = wdg_evt;
    case (st_q)
      awh_pkg::AWH_RUN: begin
        if (halt_exec_i && !wdg_evt && en_q) begin
          st_d = awh_pkg::AWH_RC_START;
          div_d = 6'h00;
          psc_d = 8'h00;
          cnt_d = 13'h0000;
          mclr_d = 1'b1;
        end
      end
      awh_pkg::AWH_RC_START: begin
        cnt_d = cnt_q + 13'h0001;
        if (ext_wake_i || flag_q) begin
          st_d = awh_pkg::AWH_STAB;
          cnt_d = 13'h0000;
        end else if (cnt_q + 13'h0001 >= 13'(awh_pkg::RC_START_CYC)) begin
          st_d = awh_pkg::AWH_COUNT;
          cnt_d = 13'h0000;
        end
      end
      awh_pkg::AWH_COUNT: begin
        if (rc_tick_i) begin
          div_d = div_q + 6'h01;
          if (div_q == 6'(awh_pkg::FIXED_DIV - 1)) begin
            psc_d = psc_q + 8'h01;
          end
        end
        if (expire || ext_wake_i) begin
          st_d = awh_pkg::AWH_STAB;
          cnt_d = 13'h0000;
        end
      end
      awh_pkg::AWH_STAB: begin
        cnt_d = cnt_q + 13'h0001;
        if (cnt_q + 13'h0001 >= stab_cyc) begin
          cnt_d = 13'h0000;
          st_d = pll_opt_i ? awh_pkg::AWH_PLL : awh_pkg::AWH_RUN;
        end
      end
      awh_pkg::AWH_PLL: begin
        cnt_d = cnt_q + 13'h0001;
        if (cnt_q + 13'h0001 >= 13'(PLL_START_CYC)) begin
          st_d = awh_pkg::AWH_RUN;
          cnt_d = 13'h0000;
        end
      end
      default: st_d = awh_pkg::AWH_RUN;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q <= awh_pkg::AWH_RUN;
      div_q <= 6'h00;
      psc_q <= 8'h00;
      cnt_q <= 13'h0000;
      mclr_q <= 1'b0;
      wdg_q <= 1'b0;
    end else begin
      st_q <= st_d;
      div_q <= div_d;
      psc_q <= psc_d;
      cnt_q <= cnt_d;
      mclr_q <= mclr_d;
      wdg_q <= wdg_d;
    end
  end

  // ---------------------------------------------------------------
  // registers and apb slave
  // ---------------------------------------------------------------
  always_comb begin
    pre_d = pre_q;
    en_d = en_q;
    meas_d = meas_q;
    flag_d = flag_q;
    msk_d = msk_q;
    rdata_d = rdata_q;
    ready_d = 1'b0;
    err_d = 1'b0;
    // setup cycle: answer and read data for the access cycle
    if (psel_i && !penable_i) begin
      ready_d = 1'b1;
      err_d = !sel_any;
      rdata_d = 32'h00000000;
      if (sel_pre) begin
        rdata_d = {24'h000000, pre_q};
      end else if (sel_csr) begin
        rdata_d = {29'h0, flag_q, meas_q, en_q};
      end else if (sel_msk) begin
        rdata_d = {30'h0, msk_q};
      end else if (sel_ist) begin
        rdata_d = {30'h0, ist_q};
      end else if (sel_sta) begin
        rdata_d = {29'h0, st_q};
      end
    end
    // access cycle: writes land here
    if (wr_acc) begin
      if (sel_pre && pwdata_i[7:0] != 8'h00) begin
        pre_d = pwdata_i[7:0];
      end else if (sel_csr) begin
        en_d = pwdata_i[awh_pkg::EN_BIT];
        meas_d = pwdata_i[awh_pkg::MEAS_BIT];
      end else if (sel_msk) begin
        msk_d = pwdata_i[awh_pkg::IRQ_WIDTH-1:0];
      end
    end
    // read of control/status clears the flag
    if (rd_acc && sel_csr) begin
      flag_d = 1'b0;
    end
    // set wins over read-clear
    if (expire) begin
      flag_d = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // sticky interrupt status
  // ---------------------------------------------------------------
  logic [awh_pkg::IRQ_WIDTH-1:0] ist_evt;
  logic [awh_pkg::IRQ_WIDTH-1:0] ist_clr;

  // event and clear vectors, one bit per source
  assign ist_evt[awh_pkg::IRQ_WAKE_BIT] = expire;
  assign ist_evt[awh_pkg::IRQ_WDG_BIT] = wdg_evt;
  assign ist_clr[awh_pkg::IRQ_WAKE_BIT] = rd_acc && (sel_ist || sel_csr);
  assign ist_clr[awh_pkg::IRQ_WDG_BIT] = rd_acc && sel_ist;

  // each bit: set wins over read-clear
  for (genvar i = 0; i < awh_pkg::IRQ_WIDTH; i++) begin : g_ist
    assign ist_d[i] = ist_evt[i] || (ist_q[i] && !ist_clr[i]);
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pre_q <= awh_pkg::PRESCALER_RST;
      en_q <= awh_pkg::CTRL_STAT_RST[awh_pkg::EN_BIT];
      meas_q <= awh_pkg::CTRL_STAT_RST[awh_pkg::MEAS_BIT];
      flag_q <= awh_pkg::CTRL_STAT_RST[awh_pkg::FLAG_BIT];
      msk_q <= '0;
      ist_q <= '0;
      rdata_q <= 32'h00000000;
      ready_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      en_q <= en_d;
      meas_q <= meas_d;
      flag_q <= flag_d;
      msk_q <= msk_d;
      ist_q <= ist_d;
      rdata_q <= rdata_d;
      ready_q <= ready_d;
      err_q <= err_d;
    end
  end

  // ---------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------
  logic run_d;
  logic osc_d;
  logic rc_d;
  logic cap_d;
  logic irq_d;
  logic osc_q;
  logic run_q;
  logic rc_q;
  logic cap_q;
  logic irq_q;

  // power controls from next state
  always_comb begin
    run_d = (st_d == awh_pkg::AWH_RUN);
    osc_d = (st_d != awh_pkg::AWH_RC_START) && (st_d != awh_pkg::AWH_COUNT);
    rc_d = (st_d == awh_pkg::AWH_RC_START) || (st_d == awh_pkg::AWH_COUNT) ||
           (meas_d && st_d == awh_pkg::AWH_RUN);
    cap_d = meas_d && (st_d == awh_pkg::AWH_RUN);
    irq_d = |(ist_d & msk_d);
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      osc_q <= 1'b1;
      run_q <= 1'b1;
      rc_q <= 1'b0;
      cap_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      osc_q <= osc_d;
      run_q <= run_d;
      rc_q <= rc_d;
      cap_q <= cap_d;
      irq_q <= irq_d;
    end
  end

  assign prdata_o = rdata_q;
  assign pready_o = ready_q;
  assign pslverr_o = err_q;
  assign main_osc_en_o = osc_q;
  assign periph_clk_en_o = run_q;
  assign cpu_run_o = run_q;
  assign rc_osc_en_o = rc_q;
  assign capture_sel_o = cap_q;
  assign irq_mask_clr_o = mclr_q;
  assign wdg_reset_o = wdg_q;
  assign wake_irq_o = flag_q;
  assign irq_o = irq_q;
endmodule : awh_top

// file: core/awh_pkg.sv
package awh_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  // printed offsets 0x49/0x4a are not multiples of four: they are indices
  localparam logic [7:0] PRESCALER_IDX = 8'h49;
  localparam logic [7:0] CTRL_STAT_IDX = 8'h4a;
  localparam logic [7:0] IRQ_MASK_IDX = 8'h4b;
  localparam logic [7:0] IRQ_STAT_IDX = 8'h4c;
  localparam logic [7:0] STATUS_IDX = 8'h4d;
  localparam logic [7:0] PRESCALER_RST = 8'hff;
  localparam logic [7:0] CTRL_STAT_RST = 8'h00;
  // control/status fields
  localparam int EN_BIT = 0;
  localparam int MEAS_BIT = 1;
  localparam int FLAG_BIT = 2;
  // interrupt status / mask fields
  localparam int IRQ_WAKE_BIT = 0;
  localparam int IRQ_WDG_BIT = 1;
  localparam int IRQ_WIDTH = 2;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int FIXED_DIV = 64;
  localparam int STAB_SHORT = 256;
  localparam int STAB_LONG = 4096;
  localparam int CLOCK_HZ = 40000000;
  localparam int RC_START_NS = 1000;
  localparam int RC_START_CYC = (RC_START_NS * (CLOCK_HZ / 1000000) + 999) / 1000;
  localparam int PLL_START_CYC_DEF = 64;
  typedef enum logic [2:0] {
    AWH_RUN,
    AWH_RC_START,
    AWH_COUNT,
    AWH_STAB,
    AWH_PLL
  } awh_state_t;
endpackage : awh_pkg

// file: verification/awh_sva.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// port checker
// ---------------------------------------------------------------
module awh_sva #(
  parameter int STAB_LONG_CYC = 16,
  parameter int PLL_START_CYC = 4
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic halt_exec_i,
  input wire logic wdg_active_i,
  input wire logic wdg_halt_opt_i,
  input wire logic long_stab_opt_i,
  input wire logic pll_opt_i,
  input wire logic main_osc_en_o,
  input wire logic periph_clk_en_o,
  input wire logic cpu_run_o,
  input wire logic rc_osc_en_o,
  input wire logic capture_sel_o,
  input wire logic irq_mask_clr_o,
  input wire logic wdg_reset_o,
  input wire logic wake_irq_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  int stab_q;
  int stab_d;
  int stab_exp;
  // cycles with oscillator on before the cpu runs again
  always_comb begin
    stab_d = cpu_run_o ? 0 : (main_osc_en_o ? stab_q + 1 : 0);
    stab_exp = (long_stab_opt_i ? STAB_LONG_CYC : awh_pkg::STAB_SHORT) +
               (pll_opt_i ? PLL_START_CYC : 0);
  end
  // stabilisation counter register
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) stab_q <= 0;
    else stab_q <= stab_d;
  end
  sequence s_access;
    psel_i && penable_i;
  endsequence
  sequence s_ctrl_read;
    psel_i && penable_i && !pwrite_i && paddr_i == {22'h0, awh_pkg::CTRL_STAT_IDX, 2'h0};
  endsequence
  chk_apb_zero_wait: assert property (s_access |-> pready_o ##1 !pready_o)
    else $error("pready missing or held");
  chk_err_with_ready: assert property (pslverr_o |-> pready_o)
    else $error("pslverr without pready");
  chk_entry_osc_off: assert property (irq_mask_clr_o |-> !main_osc_en_o && rc_osc_en_o)
    else $error("halt entry without osc switch");
  chk_no_clock_halt: assert property (!main_osc_en_o |-> !periph_clk_en_o && !cpu_run_o)
    else $error("peripherals clocked with osc off");
  chk_stab_delay: assert property ($rose(cpu_run_o) |-> stab_q >= stab_exp - 1 && stab_q <= stab_exp + 1)
    else $error("stabilisation delay wrong");
  chk_flag_wakes: assert property ($rose(wake_irq_o) |-> ##[0:1] main_osc_en_o)
    else $error("flag without oscillator restart");
  chk_read_clears: assert property (s_ctrl_read ##0 cpu_run_o |=> !wake_irq_o)
    else $error("read did not clear flag");
  chk_capture_run: assert property (capture_sel_o |-> rc_osc_en_o && cpu_run_o)
    else $error("capture outside run");
  chk_wdg_halt: assert property (halt_exec_i && wdg_active_i && wdg_halt_opt_i && cpu_run_o
    |=> wdg_reset_o && !irq_mask_clr_o)
    else $error("watchdog halt not reset");
endmodule : awh_sva

// file: verification/awh_top_tb.sv
`timescale 1ns/1ps
bind awh_top awh_sva #(.STAB_LONG_CYC(STAB_LONG_CYC), .PLL_START_CYC(PLL_START_CYC)) awh_sva_i (.*);
module awh_top_tb;
  localparam logic [31:0] A_PRE = {22'h0, awh_pkg::PRESCALER_IDX, 2'h0};
  localparam logic [31:0] A_CSR = {22'h0, awh_pkg::CTRL_STAT_IDX, 2'h0};
  localparam logic [31:0] A_MSK = {22'h0, awh_pkg::IRQ_MASK_IDX, 2'h0};
  localparam logic [31:0] A_IST = {22'h0, awh_pkg::IRQ_STAT_IDX, 2'h0};
  logic clock_i, rst_b_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, err;
  logic [31:0] paddr_i, pwdata_i, prdata_o, rd;
  logic halt_exec_i, rc_tick_i, ext_wake_i, wdg_active_i, wdg_halt_opt_i, long_stab_opt_i;
  logic pll_opt_i, main_osc_en_o, periph_clk_en_o, cpu_run_o, rc_osc_en_o, capture_sel_o;
  logic irq_mask_clr_o, wdg_reset_o, wake_irq_o, irq_o;
  int failures, checks, cyc, tk;
  awh_top #(.STAB_LONG_CYC(16), .PLL_START_CYC(4)) awh_top_i (.*);
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic stop_test();
    if (failures == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    do @(posedge clock_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clock_i);
  endtask : apb
  task automatic wait_run();
    do @(posedge clock_i); while (cpu_run_o !== 1'b1);
  endtask : wait_run
  // halt, then rc ticks until the flag rises
  task automatic do_halt();
    halt_exec_i <= 1'b1;
    @(posedge clock_i);
    halt_exec_i <= 1'b0;
    @(posedge clock_i);
    chk({main_osc_en_o, rc_osc_en_o}, 2'b01);
    repeat (44) @(posedge clock_i);
    tk = 0;
    while (wake_irq_o !== 1'b1 && tk < 600) begin
      rc_tick_i <= 1'b1;
      @(posedge clock_i);
      rc_tick_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      tk++;
    end
  endtask : do_halt
  // ---------------------------------------------------------------
  // clock and timeout
  // ---------------------------------------------------------------
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      failures++;
      stop_test();
    end
  end
  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial begin
    {failures, checks, cyc} = '0;
    {rst_b_i, psel_i, penable_i, pwrite_i, halt_exec_i, rc_tick_i, ext_wake_i} = '0;
    {wdg_active_i, wdg_halt_opt_i, pll_opt_i} = '0;
    long_stab_opt_i = 1'b1;
    paddr_i = '0;
    pwdata_i = '0;
    repeat (8) @(posedge clock_i);
    rst_b_i <= 1'b1;
    @(posedge clock_i);
    apb(0, A_PRE, 0); chk(rd, 32'h0000_00ff);
    apb(0, A_CSR, 0); chk(rd, 32'h0);
    apb(0, 32'h0000_0200, 0); chk(err, 1'b1);
    apb(1, A_CSR, 32'hff); apb(0, A_CSR, 0); chk(rd, 32'h3);
    chk({capture_sel_o, rc_osc_en_o}, 2'b11);
    apb(1, A_CSR, 32'h0); chk(capture_sel_o, 1'b0);
    apb(1, A_PRE, 32'h1); apb(1, A_PRE, 32'h0); apb(0, A_PRE, 0); chk(rd, 32'h1);
    apb(1, A_CSR, 32'h1); apb(1, A_MSK, 32'h1);
    do_halt(); chk(tk, 64);
    chk(irq_o, 1'b1);
    wait_run();
    apb(0, A_CSR, 0); chk(rd, 32'h5);
    apb(0, A_CSR, 0); chk(rd, 32'h1);
    apb(0, A_IST, 0); chk(rd, 32'h0);
    chk(irq_o, 1'b0);
    apb(1, A_PRE, 32'h2); apb(1, A_MSK, 32'h0);
    long_stab_opt_i <= 1'b0;
    pll_opt_i <= 1'b1;
    do_halt(); chk(tk, 128);
    chk(irq_o, 1'b0);
    wait_run();
    apb(0, A_CSR, 0); chk(rd, 32'h5);
    apb(0, A_IST, 0);
    long_stab_opt_i <= 1'b1;
    halt_exec_i <= 1'b1;
    @(posedge clock_i);
    halt_exec_i <= 1'b0;
    repeat (10) @(posedge clock_i);
    ext_wake_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    chk(main_osc_en_o, 1'b1);
    wait_run();
    ext_wake_i <= 1'b0;
    chk(wake_irq_o, 1'b0);
    wdg_active_i <= 1'b1;
    wdg_halt_opt_i <= 1'b1;
    halt_exec_i <= 1'b1;
    @(posedge clock_i);
    halt_exec_i <= 1'b0;
    @(posedge clock_i);
    chk({wdg_reset_o, cpu_run_o}, 2'b11);
    apb(0, A_IST, 0); chk(rd, 32'h2);
    stop_test();
  end
endmodule : awh_top_tb
